// ### rtl/rwt_reset_timers.sv
// Reset gathering, lockable guard timer, wake timer and two general down timers.
// How it works
// RULE_01: Supply below threshold resets all domains.
// RULE_02: Software reset request spares the debug port.
// RULE_03: Guard timer reset spares the wake timer.
// RULE_04: External low pin resets all domains.
// RULE_05: Guard timer starts disabled until software enables.
// RULE_06: Guard timer keeps counting during debug halt.
// RULE_07: Guard control writable only after unlock key.
// RULE_08: 32-bit guard expiry issues a system reset.
// RULE_09: Guard timer follows the core clock selection.
// RULE_10: Fast 24 MHz and slow 120 kHz clocks; FAST_DIV divides 100 MHz by 4, giving a 25 MHz fast rate.
// RULE_11: General timers count down, flag at zero.
// RULE_12: General timers use selectable source and prescale.
// RULE_13: 32-bit wake timer schedules low-power exit.
// RULE_14: Cable attach stays active and wakes system.
// RULE_15: Guard counts from reload, refresh restores it.
`timescale 1ns/1ns
module rwt_reset_timers
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Pins and analog inputs.
  input wire logic supply_good,
  input wire logic ext_reset_n,
  input wire logic attach_det,
  input wire logic debug_halt,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Domain resets, active low.
  output logic core_rst_n,
  output logic debug_port_rst_n,
  output logic periph_rst_n,
  output logic wake_timer_rst_n,
  output logic guard_rst_n,
  // Clock selection, wake and interrupt.
  output logic fast_clock_sel,
  output logic wake_req,
  output logic irq
);
  localparam int IRQ_W = rwt_pkg::IRQ_W;
  logic [1:0] sup_sync, pin_sync, att_sync;
  logic sup_ok, pin_ok, att_lvl, att_prev;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have, w_have, wr_fire;
  logic [7:0] wr_addr;
  logic wr_ok;
  logic sw_rst_req, grd_fire;
  logic [4:0] hold_cnt;
  logic [3:0] hold_kind;
  logic [3:0] rst_cause;
  logic grd_unlocked, grd_en;
  logic [31:0] grd_reload, grd_count;
  logic [31:0] wake_ctrl, wake_load, tmr_ctrl [2];
  logic [31:0] tmr_load [2];
  logic [31:0] tmr_count [3];
  logic [2:0] tmr_zero;
  logic [IRQ_W-1:0] irq_status, irq_mask, irq_set;
  logic [15:0] fast_div_cnt, slow_div_cnt;
  logic fast_tick, slow_tick, core_tick;

  // Pins and analog levels cross in through two flip-flops each.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sup_sync <= 2'b00;
      pin_sync <= 2'b00;
      att_sync <= 2'b00;
      att_prev <= 1'b0;
    end
    else
    begin
      sup_sync <= {sup_sync[0], supply_good};
      pin_sync <= {pin_sync[0], ext_reset_n};
      att_sync <= {att_sync[0], attach_det};
      att_prev <= att_sync[1];
    end
  end
  assign sup_ok = sup_sync[1];
  assign pin_ok = pin_sync[1];
  assign att_lvl = att_sync[1];

  // Fast and slow clock rates as enables divided from the system clock.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fast_div_cnt <= 16'h0000;
      slow_div_cnt <= 16'h0000;
    end
    else
    begin
      fast_div_cnt <= fast_tick ? 16'h0000 : fast_div_cnt + 16'h0001; // see RULE_10
      slow_div_cnt <= slow_tick ? 16'h0000 : slow_div_cnt + 16'h0001; // see RULE_10
    end
  end
  assign fast_tick = (fast_div_cnt == 16'(rwt_pkg::FAST_DIV - 1));
  assign slow_tick = (slow_div_cnt == 16'(rwt_pkg::SLOW_DIV - 1));
  assign core_tick = fast_clock_sel ? fast_tick : slow_tick;

  // Reset hold: kind bits are core, debug, wake timer, guard; periph follows core.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_cnt <= 5'(rwt_pkg::RST_HOLD_CYC);
      hold_kind <= 4'hf;
      rst_cause <= 4'h1;
    end
    else if (!sup_ok)
    begin
      hold_cnt <= 5'(rwt_pkg::RST_HOLD_CYC);
      hold_kind <= 4'hf; // see RULE_01
      rst_cause <= 4'h1 << rwt_pkg::CAUSE_POR;
    end
    else if (!pin_ok)
    begin
      hold_cnt <= 5'(rwt_pkg::RST_HOLD_CYC);
      hold_kind <= 4'hf; // see RULE_04
      rst_cause <= 4'h1 << rwt_pkg::CAUSE_PIN;
    end
    else if (grd_fire)
    begin
      hold_cnt <= 5'(rwt_pkg::RST_HOLD_CYC);
      hold_kind <= hold_kind | 4'b1011; // see RULE_03
      rst_cause <= 4'h1 << rwt_pkg::CAUSE_GRD; // see RULE_08
    end
    else if (sw_rst_req)
    begin
      hold_cnt <= 5'(rwt_pkg::RST_HOLD_CYC);
      hold_kind <= hold_kind | 4'b1101; // see RULE_02
      rst_cause <= 4'h1 << rwt_pkg::CAUSE_SW;
    end
    else if (hold_cnt != 5'h00)
      hold_cnt <= hold_cnt - 5'h01;
    else
      hold_kind <= 4'h0;
  end
  assign core_rst_n = !(hold_cnt != 5'h00 && hold_kind[0]);
  assign periph_rst_n = core_rst_n;
  assign debug_port_rst_n = !(hold_cnt != 5'h00 && hold_kind[1]);
  assign wake_timer_rst_n = !(hold_cnt != 5'h00 && hold_kind[2]);
  assign guard_rst_n = !(hold_cnt != 5'h00 && hold_kind[3]);

  // AXI4-Lite write side: address and data taken in either order.
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign wr_addr = aw_addr_q[7:0];
  // Strobes are kept with the data, since the master may move them once data is taken.
  assign wr_ok = wr_fire && (w_strb_q == 4'hf) && (wr_addr[1:0] == 2'b00);
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr_q <= {24'h000000, s_axi_awaddr};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr <= rwt_pkg::OFF_RST_CAUSE) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes. Only full-word writes have effect.
  assign sw_rst_req = wr_ok && wr_addr == rwt_pkg::OFF_RST_REQ
    && w_data_q == rwt_pkg::RST_REQ_KEY; // see RULE_02
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_ctrl <= 32'h0000_0000;
      wake_load <= 32'h0000_0000;
      tmr_ctrl[0] <= 32'h0000_0000;
      tmr_ctrl[1] <= 32'h0000_0000;
      tmr_load[0] <= 32'h0000_0000;
      tmr_load[1] <= 32'h0000_0000;
      irq_mask <= '0;
      fast_clock_sel <= 1'b1;
    end
    else if (wr_ok)
    begin
      unique case (wr_addr)
        rwt_pkg::OFF_WAKE_CTRL: wake_ctrl <= w_data_q;
        rwt_pkg::OFF_WAKE_LOAD: wake_load <= w_data_q;
        rwt_pkg::OFF_TMR_CTRL0: tmr_ctrl[0] <= w_data_q; // see RULE_12
        rwt_pkg::OFF_TMR_LOAD0: tmr_load[0] <= w_data_q;
        rwt_pkg::OFF_TMR_CTRL1: tmr_ctrl[1] <= w_data_q; // see RULE_12
        rwt_pkg::OFF_TMR_LOAD1: tmr_load[1] <= w_data_q;
        rwt_pkg::OFF_IRQ_MASK: irq_mask <= w_data_q[IRQ_W-1:0];
        rwt_pkg::OFF_CLK_SEL: fast_clock_sel <= w_data_q[0];
        default: ;
      endcase
    end
  end

  // Guard timer: lock, enable, reload and count on the core clock rate.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      grd_unlocked <= 1'b0;
      grd_en <= 1'b0; // see RULE_05
      grd_reload <= rwt_pkg::GRD_RELOAD_RST;
      grd_count <= rwt_pkg::GRD_RELOAD_RST;
    end
    else if (!guard_rst_n)
    begin
      grd_unlocked <= 1'b0;
      grd_en <= 1'b0;
      grd_reload <= rwt_pkg::GRD_RELOAD_RST;
      grd_count <= rwt_pkg::GRD_RELOAD_RST;
    end
    else
    begin
      if (wr_ok && wr_addr == rwt_pkg::OFF_GRD_LOCK)
        grd_unlocked <= (w_data_q == rwt_pkg::GRD_UNLOCK_KEY); // see RULE_07
      if (wr_ok && grd_unlocked && wr_addr == rwt_pkg::OFF_GRD_CTRL)
      begin
        grd_en <= w_data_q[rwt_pkg::CTRL_EN_BIT]; // see RULE_07
        grd_count <= grd_reload;
        grd_unlocked <= 1'b0;
      end
      else if (wr_ok && grd_unlocked && wr_addr == rwt_pkg::OFF_GRD_RELOAD)
      begin
        grd_reload <= w_data_q;
        grd_unlocked <= 1'b0;
      end
      else if (wr_ok && wr_addr == rwt_pkg::OFF_GRD_REFRESH
        && w_data_q == rwt_pkg::GRD_REFRESH_KEY)
        grd_count <= grd_reload; // see RULE_15
      else if (grd_en && core_tick && grd_count != 32'h0000_0000)
        grd_count <= grd_count - 32'h0000_0001; // see RULE_06, see RULE_09
    end
  end
  // Debug halt deliberately has no effect on the guard count.
  assign grd_fire = grd_en && (grd_count == 32'h0000_0000); // see RULE_08, see RULE_15

  // Wake timer and two general timers share one counter module.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      logic [31:0] ctrl_w;
      logic ld;
      logic rst_ok;
      assign ctrl_w = (gi == 2) ? wake_ctrl : tmr_ctrl[gi % 2];
      assign rst_ok = (gi == 2) ? wake_timer_rst_n : periph_rst_n;
      assign ld = !rst_ok || (wr_ok && wr_addr == ((gi == 2) ? rwt_pkg::OFF_WAKE_LOAD
        : ((gi == 0) ? rwt_pkg::OFF_TMR_LOAD0 : rwt_pkg::OFF_TMR_LOAD1)));
      rwt_down_timer u_tmr
      (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(rst_ok && ctrl_w[rwt_pkg::CTRL_EN_BIT]),
        .tick(ctrl_w[rwt_pkg::CTRL_SRC_BIT] ? fast_tick : slow_tick), // see RULE_12
        .prescale(ctrl_w[rwt_pkg::CTRL_PRE_LSB +: rwt_pkg::CTRL_PRE_W]),
        .load(ld),
        .load_value(rst_ok ? w_data_q : 32'h0000_0000),
        .count(tmr_count[gi]),
        .zero_pulse(tmr_zero[gi]) // see RULE_11, see RULE_13
      );
    end
  endgenerate

  // Sticky status: hardware set wins over write-one-to-clear.
  assign irq_set = {att_lvl && !att_prev, tmr_zero[2], tmr_zero[1], tmr_zero[0]};
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irq_status <= '0;
    else if (wr_ok && wr_addr == rwt_pkg::OFF_IRQ_STATUS)
      irq_status <= (irq_status & ~w_data_q[IRQ_W-1:0]) | irq_set; // see RULE_11
    else
      irq_status <= irq_status | irq_set;
  end
  assign irq = |(irq_status & irq_mask);
  // Attach and wake expiry wake the system regardless of the mask.
  assign wake_req = irq_status[rwt_pkg::IRQ_ATTACH] // see RULE_14
    || irq_status[rwt_pkg::IRQ_WAKE]; // see RULE_13

  // AXI4-Lite read side: one cycle after address acceptance.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        rwt_pkg::OFF_GRD_LOCK: s_axi_rdata <= {31'h0, grd_unlocked};
        rwt_pkg::OFF_GRD_CTRL: s_axi_rdata <= {31'h0, grd_en};
        rwt_pkg::OFF_GRD_RELOAD: s_axi_rdata <= grd_reload;
        rwt_pkg::OFF_GRD_COUNT: s_axi_rdata <= grd_count;
        rwt_pkg::OFF_WAKE_CTRL: s_axi_rdata <= wake_ctrl;
        rwt_pkg::OFF_WAKE_LOAD: s_axi_rdata <= wake_load;
        rwt_pkg::OFF_WAKE_COUNT: s_axi_rdata <= tmr_count[2];
        rwt_pkg::OFF_TMR_CTRL0: s_axi_rdata <= tmr_ctrl[0];
        rwt_pkg::OFF_TMR_LOAD0: s_axi_rdata <= tmr_load[0];
        rwt_pkg::OFF_TMR_COUNT0: s_axi_rdata <= tmr_count[0];
        rwt_pkg::OFF_TMR_CTRL1: s_axi_rdata <= tmr_ctrl[1];
        rwt_pkg::OFF_TMR_LOAD1: s_axi_rdata <= tmr_load[1];
        rwt_pkg::OFF_TMR_COUNT1: s_axi_rdata <= tmr_count[1];
        rwt_pkg::OFF_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
        rwt_pkg::OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
        rwt_pkg::OFF_CLK_SEL: s_axi_rdata <= {31'h0, fast_clock_sel};
        rwt_pkg::OFF_RST_CAUSE: s_axi_rdata <= {28'h0, rst_cause};
        rwt_pkg::OFF_RST_REQ: s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// ### rtl/rwt_pkg.sv
// Package of register offsets, fields, reset values and counts for the reset and timer block.
package rwt_pkg;
  localparam logic [7:0] OFF_RST_REQ = 8'h00;
  localparam logic [7:0] OFF_GRD_LOCK = 8'h04;
  localparam logic [7:0] OFF_GRD_CTRL = 8'h08;
  localparam logic [7:0] OFF_GRD_RELOAD = 8'h0c;
  localparam logic [7:0] OFF_GRD_REFRESH = 8'h10;
  localparam logic [7:0] OFF_GRD_COUNT = 8'h14;
  localparam logic [7:0] OFF_WAKE_CTRL = 8'h18;
  localparam logic [7:0] OFF_WAKE_LOAD = 8'h1c;
  localparam logic [7:0] OFF_WAKE_COUNT = 8'h20;
  localparam logic [7:0] OFF_TMR_CTRL0 = 8'h24;
  localparam logic [7:0] OFF_TMR_LOAD0 = 8'h28;
  localparam logic [7:0] OFF_TMR_COUNT0 = 8'h2c;
  localparam logic [7:0] OFF_TMR_CTRL1 = 8'h30;
  localparam logic [7:0] OFF_TMR_LOAD1 = 8'h34;
  localparam logic [7:0] OFF_TMR_COUNT1 = 8'h38;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h3c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h40;
  localparam logic [7:0] OFF_CLK_SEL = 8'h44;
  localparam logic [7:0] OFF_RST_CAUSE = 8'h48;
  localparam logic [31:0] RST_REQ_KEY = 32'h0000_0001;
  localparam logic [31:0] GRD_UNLOCK_KEY = 32'h1acc_e551;
  localparam logic [31:0] GRD_REFRESH_KEY = 32'h0000_a5a5;
  localparam logic [31:0] GRD_RELOAD_RST = 32'hffff_ffff;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_PRE_LSB = 8;
  localparam int CTRL_PRE_W = 8;
  localparam int IRQ_TMR0 = 0;
  localparam int IRQ_TMR1 = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_ATTACH = 3;
  localparam int IRQ_W = 4;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_SW = 1;
  localparam int CAUSE_GRD = 2;
  localparam int CAUSE_PIN = 3;
  localparam int CLK_MHZ = 100;
  localparam int FAST_CLOCK_KHZ = 24000;
  localparam int SLOW_CLOCK_KHZ = 120;
  localparam int FAST_DIV = (CLK_MHZ * 1000) / FAST_CLOCK_KHZ;
  localparam int SLOW_DIV = (CLK_MHZ * 1000) / SLOW_CLOCK_KHZ;
  localparam int RST_HOLD_CYC = 16;
endpackage

// ### rtl/rwt_down_timer.sv
// Generic 32-bit down-counter with enable, prescaler and reload, used by the wake and general timers.
`timescale 1ns/1ns
module rwt_down_timer
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Control.
  input wire logic enable,
  input wire logic tick,
  input wire logic [7:0] prescale,
  input wire logic load,
  input wire logic [31:0] load_value,
  // State.
  output logic [31:0] count,
  output logic zero_pulse
);
  logic [7:0] pre_cnt;
  logic step;

  assign step = enable && tick && (pre_cnt == prescale);

  // Prescaler divides the source tick by prescale plus one.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pre_cnt <= 8'h00;
    else if (load || !enable)
      pre_cnt <= 8'h00;
    else if (tick)
      pre_cnt <= (pre_cnt == prescale) ? 8'h00 : pre_cnt + 8'h01;
  end

  // Counter stops at zero and pulses once when it gets there.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= 32'h0000_0000;
      zero_pulse <= 1'b0;
    end
    else
    begin
      zero_pulse <= 1'b0;
      if (load)
        count <= load_value;
      else if (step && count != 32'h0000_0000)
      begin
        count <= count - 32'h0000_0001;
        zero_pulse <= (count == 32'h0000_0001);
      end
    end
  end
endmodule

// ### sim/rwt_reset_timers_asserts.sv
// Checker of the domain resets, clock select and wake request of the reset and timer block.
`timescale 1ns/1ns
module rwt_reset_timers_asserts
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Reset sources and attach.
  input wire logic supply_good,
  input wire logic ext_reset_n,
  input wire logic attach_det,
  // Watched outputs.
  input wire logic core_rst_n,
  input wire logic debug_port_rst_n,
  input wire logic periph_rst_n,
  input wire logic wake_timer_rst_n,
  input wire logic guard_rst_n,
  input wire logic fast_clock_sel,
  input wire logic wake_req
);
  logic [7:0] held;
  logic all_low;
  assign all_low = !core_rst_n && !debug_port_rst_n && !periph_rst_n && !wake_timer_rst_n
    && !guard_rst_n;
  // Counts the cycles the core has been held in reset, saturating.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      held <= 8'h00;
    else if (core_rst_n)
      held <= 8'h00;
    else if (held != 8'hff)
      held <= held + 8'h01;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_POR_ALL:
    assert property (!supply_good [*4] |-> all_low)
    else $error("domains not all held while supply is low");
  AST_PIN_ALL:
    assert property (!ext_reset_n [*4] |-> all_low)
    else $error("domains not all held while reset pin is low");
  AST_SW_KEEPS_DEBUG:
    assert property ((!wake_timer_rst_n && debug_port_rst_n) |-> !core_rst_n && !periph_rst_n)
    else $error("wake timer reset without core reset");
  AST_GRD_KEEPS_WAKE:
    assert property ((!debug_port_rst_n && wake_timer_rst_n) |-> !core_rst_n && !guard_rst_n)
    else $error("debug reset without core and guard reset");
  AST_GROUPS:
    assert property (core_rst_n == periph_rst_n && core_rst_n == guard_rst_n)
    else $error("core, peripheral and guard resets differ");
  AST_HOLD:
    assert property ($rose(core_rst_n) |-> held >= 8'h10)
    else $error("core reset released too early");
  AST_ATTACH_WAKE:
    assert property ($rose(attach_det) |-> ##[1:6] wake_req)
    else $error("attach did not raise wake request");
  AST_CLK_RESET:
    assert property ($rose(nrst) |-> fast_clock_sel)
    else $error("fast clock not selected after reset");
endmodule

// ### sim/test_rwt_reset_timers.sv
// Self-checking bench of the reset and timer block, driven over its register bus.
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] %0t ns got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module test_rwt_reset_timers;
  logic core_clk, nrst, supply_good, ext_reset_n, attach_det, debug_halt;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mon;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_rst_n, debug_port_rst_n, periph_rst_n, wake_timer_rst_n, guard_rst_n;
  logic fast_clock_sel, wake_req, irq;
  int fails, comparisons, cycles, t0;
  // Bit 0 core, 1 debug, 2 peripheral, 3 wake timer, 4 guard, 5 clock, 6 wake, 7 irq.
  assign mon = {irq, wake_req, fast_clock_sel, guard_rst_n, wake_timer_rst_n, periph_rst_n,
    debug_port_rst_n, core_rst_n};
  rwt_reset_timers u_dut
  (
    .core_clk, .nrst, .supply_good, .ext_reset_n, .attach_det, .debug_halt,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .core_rst_n, .debug_port_rst_n, .periph_rst_n, .wake_timer_rst_n, .guard_rst_n,
    .fast_clock_sel, .wake_req, .irq
  );
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge core_clk);
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1)
      begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge core_clk);
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, er)
  endtask
  task automatic await(input int k, input logic v, input int n);
    while (mon[k] !== v && n > 0)
    begin
      @(posedge core_clk);
      n--;
    end
    `CHK(mon[k], v)
  endtask
  task automatic restart();
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    await(0, 1'b1, 40);
  endtask
  initial
  begin
    {nrst, attach_det, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {supply_good, ext_reset_n} = 2'b11;
    s_axi_wstrb = 4'hf;
    // The debugger keeps the processor halted for the whole run.
    debug_halt = 1'b1;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    @(posedge core_clk);
    restart();
    `CHK(mon[5:0], 6'h3f)
    rdc(rwt_pkg::OFF_GRD_CTRL, 32'h1, 32'h0, 2'b00);
    rdc(rwt_pkg::OFF_GRD_RELOAD, 32'hffff_ffff, rwt_pkg::GRD_RELOAD_RST, 2'b00);
    rdc(8'hfc, 32'h0, 32'h0, 2'b10);
    wr(8'hfc, 32'h0, 2'b10);
    wr(rwt_pkg::OFF_GRD_CTRL, 32'h1, 2'b00);
    rdc(rwt_pkg::OFF_GRD_CTRL, 32'h1, 32'h0, 2'b00);
    wr(rwt_pkg::OFF_GRD_LOCK, rwt_pkg::GRD_UNLOCK_KEY, 2'b00);
    wr(rwt_pkg::OFF_GRD_RELOAD, 32'h14, 2'b00);
    wr(rwt_pkg::OFF_GRD_LOCK, rwt_pkg::GRD_UNLOCK_KEY, 2'b00);
    wr(rwt_pkg::OFF_GRD_CTRL, 32'h1, 2'b00);
    rdc(rwt_pkg::OFF_GRD_CTRL, 32'h1, 32'h1, 2'b00);
    repeat (20) wr(rwt_pkg::OFF_GRD_REFRESH, rwt_pkg::GRD_REFRESH_KEY, 2'b00);
    `CHK(mon[4:0], 5'h1f)
    await(0, 1'b0, 200);
    @(posedge core_clk);
    `CHK(mon[4:0], 5'h08)
    rdc(rwt_pkg::OFF_RST_CAUSE, 32'hf, 32'h4, 2'b00);
    restart();
    wr(rwt_pkg::OFF_RST_REQ, rwt_pkg::RST_REQ_KEY, 2'b00);
    await(0, 1'b0, 20);
    @(posedge core_clk);
    `CHK(mon[4:0], 5'h02)
    rdc(rwt_pkg::OFF_RST_CAUSE, 32'hf, 32'h2, 2'b00);
    restart();
    for (int s = 0; s < 2; s++)
    begin
      if (s == 0)
        ext_reset_n <= 1'b0;
      else
        supply_good <= 1'b0;
      await(0, 1'b0, 10);
      @(posedge core_clk);
      `CHK(mon[4:0], 5'h00)
      {ext_reset_n, supply_good} <= 2'b11;
      await(0, 1'b1, 40);
      rdc(rwt_pkg::OFF_RST_CAUSE, 32'hf, (s == 0) ? 32'h8 : 32'h1, 2'b00);
    end
    wr(rwt_pkg::OFF_CLK_SEL, 32'h0, 2'b00);
    `CHK(fast_clock_sel, 1'b0)
    // On the slow rate a reload of two cannot expire within 100 cycles.
    wr(rwt_pkg::OFF_GRD_LOCK, rwt_pkg::GRD_UNLOCK_KEY, 2'b00);
    wr(rwt_pkg::OFF_GRD_RELOAD, 32'h2, 2'b00);
    wr(rwt_pkg::OFF_GRD_LOCK, rwt_pkg::GRD_UNLOCK_KEY, 2'b00);
    wr(rwt_pkg::OFF_GRD_CTRL, 32'h1, 2'b00);
    repeat (100) @(posedge core_clk);
    `CHK(mon[0], 1'b1)
    await(0, 1'b0, 2000);
    restart();
    wr(rwt_pkg::OFF_CLK_SEL, 32'h1, 2'b00);
    `CHK(fast_clock_sel, 1'b1)
    // A partial write is answered but leaves the register alone.
    s_axi_wstrb <= 4'h3;
    wr(rwt_pkg::OFF_IRQ_MASK, 32'hf, 2'b00);
    s_axi_wstrb <= 4'hf;
    rdc(rwt_pkg::OFF_IRQ_MASK, 32'hf, 32'h0, 2'b00);
    for (int i = 0; i < 2; i++)
    begin
      wr(rwt_pkg::OFF_IRQ_MASK, 32'h1 << i, 2'b00);
      wr(rwt_pkg::OFF_TMR_CTRL0 + 8'(12 * i), 32'h3 | (32'(i) << 8), 2'b00);
      t0 = cycles;
      wr(rwt_pkg::OFF_TMR_LOAD0 + 8'(12 * i), 32'h6, 2'b00);
      `CHK(irq, 1'b0)
      await(7, 1'b1, 200);
      `CHK((cycles - t0) inside {[20 * (i + 1) : 30 * (i + 1) + 10]}, 1'b1)
      rdc(rwt_pkg::OFF_TMR_COUNT0 + 8'(12 * i), 32'hffff_ffff, 32'h0, 2'b00);
      rdc(rwt_pkg::OFF_IRQ_STATUS, 32'hf, 32'h1 << i, 2'b00);
      wr(rwt_pkg::OFF_IRQ_STATUS, 32'h1 << i, 2'b00);
      `CHK(irq, 1'b0)
    end
    wr(rwt_pkg::OFF_IRQ_MASK, 32'h4, 2'b00);
    wr(rwt_pkg::OFF_WAKE_CTRL, 32'h3, 2'b00);
    wr(rwt_pkg::OFF_WAKE_LOAD, 32'h6, 2'b00);
    await(7, 1'b1, 200);
    `CHK(wake_req, 1'b1)
    wr(rwt_pkg::OFF_IRQ_STATUS, 32'h4, 2'b00);
    `CHK(mon[7:6], 2'b00)
    wr(rwt_pkg::OFF_IRQ_MASK, 32'h0, 2'b00);
    attach_det <= 1'b1;
    await(6, 1'b1, 10);
    `CHK(irq, 1'b0)
    rdc(rwt_pkg::OFF_IRQ_STATUS, 32'h8, 32'h8, 2'b00);
    wr(rwt_pkg::OFF_IRQ_MASK, 32'h8, 2'b00);
    `CHK(irq, 1'b1)
    wr(rwt_pkg::OFF_IRQ_STATUS, 32'h8, 2'b00);
    `CHK(mon[7:6], 2'b00)
    report_and_stop();
  end
endmodule
bind rwt_reset_timers rwt_reset_timers_asserts u_ast
(
  .core_clk, .nrst, .supply_good, .ext_reset_n, .attach_det, .core_rst_n, .debug_port_rst_n,
  .periph_rst_n, .wake_timer_rst_n, .guard_rst_n, .fast_clock_sel, .wake_req
);
